// *** logic/gips_irq_polarity.sv ***
// Purpose: per-pin interrupt polarity register with set and clear aliases
// Assumes: AHB-Lite single word transfers, zero wait states, OKAY only
// Notes:   one polarity state is shared by the set and clear views
//          a read right behind a write returns the written value, since
//          read data is taken from the next state of the register
//          the controller base address is decoded outside, into hsel
//
// Contract
// (R01) sixteen polarity set bits, one per pin, in bits 15 down to 0
// (R02) writing zero to a set bit leaves that pin's polarity alone
// (R03) writing one to a set bit makes the pin high level or rising
// (R04) read zero means low level or falling edge for that pin
// (R05) read one means high level or rising edge for that pin
// (R06) a clear register returns selected pins to low or falling polarity
// (R07) bit n controls pin n; one instance per controller at its base
// (R08) after reset every polarity bit is zero
`timescale 1ns/1ns
module gips_irq_polarity
   import gips_pkg::*;
#(
   parameter int PINS = GIPS_PIN_COUNT
) (
   input  wire  logic            clk,
   input  wire  logic            srst,
   input  wire  logic            hsel,
   input  wire  logic [31:0]     haddr,
   input  wire  logic [1:0]      htrans,
   input  wire  logic            hwrite,
   input  wire  logic [2:0]      hsize,
   input  wire  logic [31:0]     hwdata,
   input  wire  logic            hready,
   output logic                  hreadyout,
   output logic [31:0]           hrdata,
   output logic                  hresp,
   output logic [PINS-1:0]       irq_polarity,
   output logic [PINS-1:0]       irq_trigger_type
);

   // ------------------------------------------------------------------
   // address phase capture
   // ------------------------------------------------------------------
   gips_aphase_s aph_reg;
   gips_aphase_s aph_next;
   logic         act_reg;
   logic         act_next;
   logic         take;

   // a transfer is taken only when the previous one has completed;
   // hsize is not decoded, so only whole-word transfers are supported
   assign take = hsel && hready && (htrans == GIPS_HTRANS_NONSEQ ||
                                    htrans == GIPS_HTRANS_SEQ);

   always_comb begin
      act_next      = take;
      aph_next      = aph_reg;
      if (take) begin
         aph_next.wr   = hwrite;
         aph_next.addr = haddr[11:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         act_reg <= 1'b0;
         aph_reg <= '0;
      end else begin
         act_reg <= act_next;
         aph_reg <= aph_next;
      end
   end

   // ------------------------------------------------------------------
   // polarity and trigger type state
   // ------------------------------------------------------------------
   logic [PINS-1:0] pol_reg;
   logic [PINS-1:0] pol_next;
   logic [PINS-1:0] type_reg;
   logic [PINS-1:0] type_next;
   logic            wr_set;
   logic            wr_clr;
   logic            wr_type;

   assign wr_set  = act_reg && aph_reg.wr && aph_reg.addr == GIPS_OFS_POL_SET;
   assign wr_clr  = act_reg && aph_reg.wr && aph_reg.addr == GIPS_OFS_POL_CLR;
   assign wr_type = act_reg && aph_reg.wr && aph_reg.addr == GIPS_OFS_TRIG_TYPE;

   // per pin: bit n of hwdata acts on pin n only; zeros in a set or clear write change nothing
   // set is tested first, so set wins if both aliases ever met at once
   genvar gi;
   generate
      for (gi = 0; gi < PINS; gi++) begin : g_pin
         always_comb begin
            pol_next[gi] = pol_reg[gi];                        // [R02] [R07]
            if (wr_set && hwdata[gi]) begin
               pol_next[gi] = 1'b1;                            // [R03] [R01]
            end else if (wr_clr && hwdata[gi]) begin
               pol_next[gi] = 1'b0;                            // [R06]
            end
            type_next[gi] = wr_type ? hwdata[gi] : type_reg[gi];
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (srst) begin
         pol_reg  <= GIPS_POL_RESET[PINS-1:0];                 // [R08]
         type_reg <= GIPS_TYPE_RESET[PINS-1:0];
      end else begin
         pol_reg  <= pol_next;
         type_reg <= type_next;
      end
   end

   // ------------------------------------------------------------------
   // registered read data
   // ------------------------------------------------------------------
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   // read data is registered from the address phase so it stands in the
   // data phase; it is taken from the next state, so a read pipelined
   // right behind a write already returns the written value
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (take && !hwrite) begin
         unique case (haddr[11:0])
            GIPS_OFS_POL_SET,
            GIPS_OFS_POL_CLR:   rdata_next[PINS-1:0] = pol_next;  // [R04] [R05]
            GIPS_OFS_TRIG_TYPE: rdata_next[PINS-1:0] = type_next;
            default:            rdata_next = 32'h0000_0000;    // unmapped reads zero
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ------------------------------------------------------------------
   // bus response
   // ------------------------------------------------------------------
   logic ready_reg;
   logic ready_next;
   logic resp_reg;
   logic resp_next;

   // no slow path sits behind this slave, so ready stays high and the
   // answer is always OKAY; both still leave a flip-flop so that every
   // output of the block comes from a register
   always_comb begin
      ready_next = 1'b1;
      resp_next  = 1'b0;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ready_reg <= 1'b1;   // ready in reset too: a master may start at once
         resp_reg  <= 1'b0;
      end else begin
         ready_reg <= ready_next;
         resp_reg  <= resp_next;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   // outputs are plain copies of registers, no logic after the flops
   assign hrdata           = rdata_reg;
   assign hreadyout        = ready_reg;
   assign hresp            = resp_reg;
   assign irq_polarity     = pol_reg;
   assign irq_trigger_type = type_reg;

   // ------------------------------------------------------------------
   // checks: write views of the shared polarity
   // ------------------------------------------------------------------
   // data phase of a write to each address; its address phase was taken
   // one cycle earlier and now sits in aph_reg
   sequence s_set_write;
      act_reg && aph_reg.wr && aph_reg.addr == GIPS_OFS_POL_SET;
   endsequence

   sequence s_clr_write;
      act_reg && aph_reg.wr && aph_reg.addr == GIPS_OFS_POL_CLR;
   endsequence

   sequence s_type_write;
      act_reg && aph_reg.wr && aph_reg.addr == GIPS_OFS_TRIG_TYPE;
   endsequence

   chk_set_bits_rise: assert property (@(posedge clk) disable iff (srst)  // [R03]
      s_set_write |=> ((irq_polarity & $past(hwdata[PINS-1:0])) ==
                       $past(hwdata[PINS-1:0])))
      else $error("set write did not raise polarity bits");

   chk_zero_keeps: assert property (@(posedge clk) disable iff (srst)  // [R02]
      s_set_write |=> ((irq_polarity & ~$past(hwdata[PINS-1:0])) ==
                       ($past(irq_polarity) & ~$past(hwdata[PINS-1:0]))))
      else $error("zero in set write changed a pin");

   // a set write may only raise bits, a clear write may only lower them
   chk_set_no_fall: assert property (@(posedge clk) disable iff (srst)  // [R03]
      s_set_write |=> (($past(irq_polarity) & ~irq_polarity) == '0))
      else $error("set write lowered a polarity bit");

   // clear ones must land even though set is tested first
   chk_clear_bits: assert property (@(posedge clk) disable iff (srst)  // [R06]
      (wr_clr && !wr_set) |=> ((irq_polarity & $past(hwdata[PINS-1:0])) == '0))
      else $error("clear write left polarity bits set");

   chk_clear_keeps: assert property (@(posedge clk) disable iff (srst)  // [R06]
      s_clr_write |=> ((irq_polarity & ~$past(hwdata[PINS-1:0])) ==
                       ($past(irq_polarity) & ~$past(hwdata[PINS-1:0]))))
      else $error("zero in clear write changed a pin");

   chk_clear_no_rise: assert property (@(posedge clk) disable iff (srst)  // [R06]
      s_clr_write |=> ((irq_polarity & ~$past(irq_polarity)) == '0))
      else $error("clear write raised a polarity bit");

   // trigger type is plain read-write state next to the polarity
   chk_type_write: assert property (@(posedge clk) disable iff (srst)
      s_type_write |=> irq_trigger_type == $past(hwdata[PINS-1:0]))
      else $error("trigger type write not stored");

   chk_type_hold: assert property (@(posedge clk) disable iff (srst)
      !wr_type |=> $stable(irq_trigger_type))
      else $error("trigger type changed without a write");

   // with no data phase in flight nothing may move
   chk_idle_stable: assert property (@(posedge clk) disable iff (srst)  // [R07]
      !act_reg |=> irq_polarity == $past(irq_polarity))
      else $error("polarity changed without a write");

   // a set write must not spill into the trigger type
   chk_pin_alone: assert property (@(posedge clk) disable iff (srst)  // [R07]
      s_set_write |=> $stable(irq_trigger_type))
      else $error("set write disturbed trigger type");

   // ------------------------------------------------------------------
   // checks: read path
   // ------------------------------------------------------------------
   // address phase of a read with no write data phase in front, so the
   // registered read data must equal the settled register
   sequence s_set_read;
      take && !hwrite && !act_reg && haddr[11:0] == GIPS_OFS_POL_SET;
   endsequence

   sequence s_clr_read;
      take && !hwrite && !act_reg && haddr[11:0] == GIPS_OFS_POL_CLR;
   endsequence

   sequence s_type_read;
      take && !hwrite && !act_reg && haddr[11:0] == GIPS_OFS_TRIG_TYPE;
   endsequence

   chk_read_shows: assert property (@(posedge clk) disable iff (srst)  // [R04] [R05]
      s_set_read ##1 1'b1 |-> hrdata[PINS-1:0] == irq_polarity)
      else $error("polarity read mismatch");

   // the clear alias reads the same shared state as the set alias
   chk_clear_view: assert property (@(posedge clk) disable iff (srst)  // [R04] [R05] [R06]
      s_clr_read ##1 1'b1 |-> hrdata[PINS-1:0] == irq_polarity)
      else $error("clear alias read mismatch");

   chk_type_view: assert property (@(posedge clk) disable iff (srst)
      s_type_read ##1 1'b1 |-> hrdata[PINS-1:0] == irq_trigger_type)
      else $error("trigger type read mismatch");

   // pins above PINS do not exist; their read bits stay zero
   chk_upper_zero: assert property (@(posedge clk) disable iff (srst)  // [R01]
      hrdata[31:PINS] == '0)
      else $error("upper read bits not zero");

   // read data is zero outside a read data phase, so stale values never leak
   chk_rdata_quiet: assert property (@(posedge clk) disable iff (srst)
      !(take && !hwrite) |=> hrdata == 32'h0000_0000)
      else $error("read data outside a read data phase");

   // ------------------------------------------------------------------
   // checks: bus response and reset
   // ------------------------------------------------------------------
   // the slave never stretches a transfer nor signals an error
   chk_ready_high: assert property (@(posedge clk) disable iff (srst)
      hreadyout == 1'b1)
      else $error("slave inserted a wait state");

   chk_resp_okay: assert property (@(posedge clk) disable iff (srst)
      hresp == 1'b0)
      else $error("slave answered with an error");

   // sync reset: the cycle after any reset edge must show cleared state
   chk_reset_zero: assert property (@(posedge clk)  // [R08]
      $past(srst) |-> irq_polarity == '0)
      else $error("polarity not zero after reset");

   chk_reset_type: assert property (@(posedge clk)
      $past(srst) |-> irq_trigger_type == '0)
      else $error("trigger type not zero after reset");

   chk_reset_rdata: assert property (@(posedge clk)
      $past(srst) |-> hrdata == 32'h0000_0000)
      else $error("read data not zero after reset");

endmodule

// *** logic/gips_pkg.sv ***
// Purpose: shared constants and types for the interrupt polarity set block
// Assumes: 32-bit AHB-Lite register bus, 16 controller pins
// Notes:   offsets are byte addresses within one controller's window
package gips_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [11:0] GIPS_OFS_POL_SET   = 12'h030; // set alias of polarity
   localparam logic [11:0] GIPS_OFS_POL_CLR   = 12'h034; // clear alias of polarity
   localparam logic [11:0] GIPS_OFS_TRIG_TYPE = 12'h038; // level or edge per pin
   localparam int          GIPS_PIN_COUNT     = 16;
   localparam logic [15:0] GIPS_POL_RESET     = 16'h0000;
   localparam logic [15:0] GIPS_TYPE_RESET    = 16'h0000;

   // ------------------------------------------------------------------
   // bus transfer codes
   // ------------------------------------------------------------------
   localparam logic [1:0]  GIPS_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]  GIPS_HTRANS_SEQ    = 2'h3;

   // captured address phase
   typedef struct packed {
      logic        wr;
      logic [11:0] addr;
   } gips_aphase_s;

endpackage

// *** sim/gips_irq_polarity_test.sv ***
// Purpose: self-checking bench for the interrupt polarity set block
// Assumes: zero wait state slave, hready looped back from hreadyout
// Notes:   expectations come from masks applied here, not from the design
`timescale 1ns/1ns
module gips_irq_polarity_test
   import gips_pkg::*;
;
   logic        clk, srst, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [15:0] irq_polarity, irq_trigger_type;
   int          miscompares = 0;
   int          num_checks = 0;

   assign hready = hreadyout;  // single slave drives the bus ready
   gips_irq_polarity dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .irq_polarity(irq_polarity), .irq_trigger_type(irq_trigger_type));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ------------------------------------------------------------------
   // bus and check tasks
   // ------------------------------------------------------------------
   task automatic conclude();
      if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // bounded wait for hready at a rising edge; a hang ends the run
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) begin
         miscompares++;
         conclude();
      end
   endtask

   // one single word transfer; entered just after a rising edge
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= {20'h00000, a};
      hwrite <= wr;
      htrans <= GIPS_HTRANS_NONSEQ;
      hsize  <= 3'h2;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;  // taken at the edge that closes the data phase
      chk("hresp", 32'h00000000, {31'h0, hresp});
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h00000000, r);
      chk(nm, e, r);
   endtask

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      srst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
      hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd("pol_rst", GIPS_OFS_POL_SET, 32'h00000000);
      wr(GIPS_OFS_POL_SET, 32'h000000A5);
      #1 chk("pol_out", 32'h000000A5, {16'h0, irq_polarity});
      wr(GIPS_OFS_POL_SET, 32'h00000000);
      rd("pol_zero", GIPS_OFS_POL_SET, 32'h000000A5);
      wr(GIPS_OFS_POL_SET, 32'hFFFF8100);
      rd("pol_wide", GIPS_OFS_POL_SET, 32'h000081A5);
      wr(GIPS_OFS_POL_CLR, 32'h00008005);
      rd("pol_clr", GIPS_OFS_POL_CLR, 32'h000001A0);
      #1 chk("pol_pin", 32'h000001A0, {16'h0, irq_polarity});
      wr(GIPS_OFS_TRIG_TYPE, 32'h00001234);
      rd("trig", GIPS_OFS_TRIG_TYPE, 32'h00001234);
      #1 chk("trig_out", 32'h00001234, {16'h0, irq_trigger_type});
      rd("unmapped", 12'h0FC, 32'h00000000);
      // reset in mid-run must drop all stored polarity
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1 chk("pol_rerst", 32'h00000000, {16'h0, irq_polarity});
      chk("trig_rerst", 32'h00000000, {16'h0, irq_trigger_type});
      rd("pol_rerd", GIPS_OFS_POL_SET, 32'h00000000);
      conclude();
   end
endmodule
